/* hdl/i2cam_cfg.svh */
// constants for the i2c slave address match block
`ifndef I2CAM_CFG_SVH
`define I2CAM_CFG_SVH

// register indexes on the plain register port
`define I2CAM_OFS_CTRL     4'h0
`define I2CAM_OFS_STAT     4'h1
`define I2CAM_OFS_ADDR     4'h2
`define I2CAM_OFS_RXDATA   4'h3
`define I2CAM_OFS_IRQ_STAT 4'h4
`define I2CAM_OFS_IRQ_MASK 4'h5

// control register fields
`define I2CAM_CTRL_EN_BIT  5
`define I2CAM_CTRL_CKP_BIT 4

// mode field codes
`define I2CAM_MODE_S7      4'h6
`define I2CAM_MODE_S10     4'h7
`define I2CAM_MODE_MSKLOAD 4'h9
`define I2CAM_MODE_S7_SP   4'hE
`define I2CAM_MODE_S10_SP  4'hF

// status register writable bits (speed select, clock edge)
`define I2CAM_STAT_WR_MASK 8'hC0

// interrupt bit positions
`define I2CAM_IRQ_ADDR  0
`define I2CAM_IRQ_BYTE  1
`define I2CAM_IRQ_START 2
`define I2CAM_IRQ_STOP  3
`define I2CAM_IRQ_W     4

// reset values
`define I2CAM_RST_CTRL 8'h00
`define I2CAM_RST_MASK 8'hFF
`define I2CAM_RST_ADDR 8'h00

// bits per byte on the bus, counted from zero
`define I2CAM_LAST_BIT 3'h7

`endif

/* hdl/i2cam_pkg.sv */
// types for the i2c slave address match block
package i2cam_pkg;

  typedef struct packed {
    logic speed_sel;
    logic clk_edge;
    logic data_addr;
    logic stop_seen;
    logic start_seen;
    logic read_write;
    logic addr_update;
    logic buf_full;
  } i2cam_stat_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_ACK,
    ST_WAIT
  } i2cam_state_t;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_LOW,
    PH_DATA
  } i2cam_phase_t;

endpackage

/* hdl/i2cam_sync.sv */
// two flip-flop synchroniser for pin inputs
module i2cam_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q[i] <= 1'b1;
        q_o[i]    <= 1'b1;
      end else begin
        meta_q[i] <= d_i[i];
        q_o[i]    <= meta_q[i];
      end
    end
  end

endmodule

/* hdl/i2cam_top.sv */
// i2c slave address recognition, status and mask registers
`include "i2cam_cfg.svh"

// Behaviour
// - speed bit set disables slew limiting
// - set mask bit compares address bit
// - cleared mask bit ignores address bit
// - ten-bit mode, low byte only: mask bit zero applies
// - other modes ignore mask bit zero
// - eight-bit own address, reset zero
// - mask-load mode maps mask at address
module i2cam_top import i2cam_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oen_o,
  // to the rest of the port
  output logic            slew_limit_o,
  output logic            buf_full_o,
  output logic      [7:0] rx_byte_o,
  output logic      [3:0] port_mode_o,
  // interrupt
  output logic            irq_o
);

  logic [1:0]   rst_sync_q;
  logic         rst_n;
  logic         scl_s;
  logic         sda_s;
  logic         scl_prev_q;
  logic         sda_prev_q;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;
  logic [7:0]   ctrl_q;
  logic [7:0]   own_addr_q;
  logic [7:0]   addr_mask_q;
  i2cam_stat_t  stat_q;
  logic [7:0]   rx_q;
  logic [6:0]   shift_q;
  logic [2:0]   bit_cnt_q;
  i2cam_state_t state_q;
  i2cam_phase_t phase_q;
  logic         ack_drv_q;
  logic [`I2CAM_IRQ_W-1:0] irq_stat_q;
  logic [`I2CAM_IRQ_W-1:0] irq_mask_q;
  logic [`I2CAM_IRQ_W-1:0] irq_ev;
  logic [7:0]   rdata_q;
  logic [3:0]   mode;
  logic         enabled;
  logic         slave_mode;
  logic         ten_bit;
  logic         mask_sel;
  logic [7:0]   rx_full;
  logic [7:0]   eff_mask;
  logic         addr_match;
  logic         byte_done;
  logic         ack_go;
  logic         addr_hit;
  logic         low_hit;
  logic         data_in;
  logic         wr_ctrl;
  logic         wr_stat;
  logic         wr_addr;
  logic         wr_irq_stat;
  logic         wr_irq_mask;
  logic         rd_rx;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  i2cam_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     ({scl_i, sda_i}),
    .q_o     ({scl_s, sda_s})
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign mode       = ctrl_q[3:0];
  assign enabled    = ctrl_q[`I2CAM_CTRL_EN_BIT];
  assign ten_bit    = (mode == `I2CAM_MODE_S10) || (mode == `I2CAM_MODE_S10_SP);
  assign slave_mode = ten_bit || (mode == `I2CAM_MODE_S7) || (mode == `I2CAM_MODE_S7_SP);
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  // sda moving while scl stays high marks start or stop
  assign start_ev   = enabled & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev    = enabled & scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // register port decode
  // mask takes over the address slot
  assign mask_sel    = (mode == `I2CAM_MODE_MSKLOAD);
  assign wr_ctrl     = reg_we_i && (reg_addr_i == `I2CAM_OFS_CTRL);
  assign wr_stat     = reg_we_i && (reg_addr_i == `I2CAM_OFS_STAT);
  assign wr_addr     = reg_we_i && (reg_addr_i == `I2CAM_OFS_ADDR);
  assign wr_irq_stat = reg_we_i && (reg_addr_i == `I2CAM_OFS_IRQ_STAT);
  assign wr_irq_mask = reg_we_i && (reg_addr_i == `I2CAM_OFS_IRQ_MASK);
  assign rd_rx       = reg_re_i && (reg_addr_i == `I2CAM_OFS_RXDATA);

  // address comparison
  assign rx_full = {shift_q, sda_s};
  always_comb begin
    eff_mask = addr_mask_q;
    // bit zero is the direction bit here
    if (!(ten_bit && (phase_q == PH_LOW))) begin
      eff_mask[0] = 1'b0;
    end
  end
  // masked bits must equal own address
  // low ten-bit byte uses mask bit zero
  assign addr_match = ((rx_full ^ own_addr_q) & eff_mask) == 8'h00;

  assign byte_done = (state_q == ST_SHIFT) && scl_rise && (bit_cnt_q == `I2CAM_LAST_BIT);
  assign addr_hit  = byte_done && (phase_q == PH_ADDR) && slave_mode && addr_match;
  assign low_hit   = byte_done && (phase_q == PH_LOW) && addr_match;
  // an unread byte is refused so it is not lost silently
  assign data_in   = byte_done && (phase_q == PH_DATA) && !stat_q.buf_full;
  assign ack_go    = addr_hit || low_hit || data_in;

  // bus sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR;
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
      ack_drv_q <= 1'b0;
    end else if (!enabled) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR;
      bit_cnt_q <= 3'h0;
      ack_drv_q <= 1'b0;
    end else if (start_ev) begin
      state_q   <= ST_SHIFT;
      phase_q   <= PH_ADDR;
      bit_cnt_q <= 3'h0;
      ack_drv_q <= 1'b0;
    end else if (stop_ev) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR;
      ack_drv_q <= 1'b0;
    end else begin
      case (state_q)
        ST_SHIFT: begin
          if (scl_rise) begin
            shift_q   <= rx_full[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done) begin
              state_q <= ack_go ? ST_ACK : ST_WAIT;
              if (addr_hit) begin
                phase_q <= ten_bit ? PH_LOW : PH_DATA;
              end else if (low_hit) begin
                phase_q <= PH_DATA;
              end
            end
          end
        end
        ST_ACK: begin
          // hold sda low from the eighth fall to the ninth fall
          if (scl_fall) begin
            ack_drv_q <= ~ack_drv_q;
            if (ack_drv_q) begin
              bit_cnt_q <= 3'h0;
              // no transmit path: a read transfer is left in the wait state
              state_q   <= (phase_q == PH_DATA && stat_q.read_write) ? ST_WAIT : ST_SHIFT;
            end
          end
        end
        ST_WAIT: begin
          state_q <= ST_WAIT;
        end
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // control, own address and mask registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `I2CAM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      own_addr_q <= `I2CAM_RST_ADDR;
    end else if (wr_addr && !mask_sel) begin
      own_addr_q <= reg_wdata_i;
    end
  end

  // mask written only in mask-load mode
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_mask_q <= `I2CAM_RST_MASK;
    end else if (wr_addr && mask_sel) begin
      addr_mask_q <= reg_wdata_i;
    end
  end

  // received byte holding register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 8'h00;
    end else if (addr_hit || low_hit || data_in) begin
      rx_q <= rx_full;
    end
  end

  // status register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      if (wr_stat) begin
        stat_q.speed_sel <= reg_wdata_i[7];
        stat_q.clk_edge  <= reg_wdata_i[6];
      end
      if (!enabled) begin
        stat_q.start_seen <= 1'b0;
        stat_q.stop_seen  <= 1'b0;
      end else if (start_ev) begin
        stat_q.start_seen <= 1'b1;
        stat_q.stop_seen  <= 1'b0;
      end else if (stop_ev) begin
        stat_q.start_seen <= 1'b0;
        stat_q.stop_seen  <= 1'b1;
      end
      if ((addr_hit && !ten_bit) || low_hit) begin
        stat_q.data_addr <= 1'b0;
      end else if (data_in) begin
        stat_q.data_addr <= 1'b1;
      end
      if (addr_hit && !ten_bit) begin
        stat_q.read_write <= rx_full[0];
      end
      // update flag: hardware set wins over the address write
      if (ten_bit && (addr_hit || low_hit)) begin
        stat_q.addr_update <= 1'b1;
      end else if (wr_addr && !mask_sel) begin
        stat_q.addr_update <= 1'b0;
      end
      // buffer full: a new byte wins over the clearing read
      if ((addr_hit && !ten_bit) || low_hit || data_in) begin
        stat_q.buf_full <= 1'b1;
      end else if (rd_rx) begin
        stat_q.buf_full <= 1'b0;
      end
    end
  end

  // interrupt status, write one to clear, set wins
  assign irq_ev[`I2CAM_IRQ_ADDR]  = (addr_hit && !ten_bit) || low_hit;
  assign irq_ev[`I2CAM_IRQ_BYTE]  = data_in;
  assign irq_ev[`I2CAM_IRQ_START] = start_ev;
  assign irq_ev[`I2CAM_IRQ_STOP]  = stop_ev;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_ev | (irq_stat_q & ~(wr_irq_stat ? reg_wdata_i[`I2CAM_IRQ_W-1:0]
                                                          : {`I2CAM_IRQ_W{1'b0}}));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_q <= reg_wdata_i[`I2CAM_IRQ_W-1:0];
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `I2CAM_OFS_CTRL:     rdata_q <= ctrl_q;
        `I2CAM_OFS_STAT:     rdata_q <= stat_q;
        `I2CAM_OFS_ADDR:     rdata_q <= mask_sel ? addr_mask_q : own_addr_q;
        `I2CAM_OFS_RXDATA:   rdata_q <= rx_q;
        `I2CAM_OFS_IRQ_STAT: rdata_q <= {4'h0, irq_stat_q};
        `I2CAM_OFS_IRQ_MASK: rdata_q <= {4'h0, irq_mask_q};
        default:             rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign sda_o        = 1'b0;
  assign sda_oen_o    = ~ack_drv_q;
  // speed bit set turns slew limiting off
  assign slew_limit_o = ~stat_q.speed_sel;
  assign buf_full_o   = stat_q.buf_full;
  assign rx_byte_o    = rx_q;
  assign port_mode_o  = mode;
  assign irq_o        = |(irq_stat_q & irq_mask_q);

endmodule

/* tb/i2cam_master.sv */
// behavioural i2c bus master for the link side
module i2cam_master import i2cam_pkg::*; (
  // link pins, released level is the pull-up high
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter of the 160 ns link period
  localparam int Q = 40;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start();
    sda_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_o = 1'b0;
    #(2*Q);
    scl_o = 1'b0;
    #Q;
  endtask

  // msb first, then release for the ack bit
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #Q;
      scl_o = 1'b1;
      #(2*Q);
      scl_o = 1'b0;
      #Q;
    end
    sda_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    ack = !sda_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #(2*Q);
    sda_o = 1'b1;
    #(2*Q);
  endtask
endmodule

/* tb/i2cam_properties.sv */
// port-level checks for the i2c slave address match block
module i2cam_properties import i2cam_pkg::*; (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_we_i,
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // link pins and side outputs
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oen_o,
  input wire logic       slew_limit_o,
  input wire logic       buf_full_o,
  input wire logic [7:0] rx_byte_o,
  input wire logic [3:0] port_mode_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_slew_speed: assert property (
    reg_we_i && reg_addr_i == 4'h1 |=> slew_limit_o == !$past(reg_wdata_i[7]))
    else $error("slew limit wrong");
  a_mode_follow: assert property (
    reg_we_i && reg_addr_i == 4'h0 |=> port_mode_o == $past(reg_wdata_i[3:0]))
    else $error("mode output wrong");
  a_own_rdback: assert property (
    reg_we_i && reg_addr_i == 4'h2 && port_mode_o != 4'h9 ##1 !reg_we_i
    ##1 reg_re_i && reg_addr_i == 4'h2 |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("own address readback wrong");
  a_mask_rdback: assert property (
    reg_we_i && reg_addr_i == 4'h2 && port_mode_o == 4'h9 ##1 !reg_we_i
    ##1 reg_re_i && reg_addr_i == 4'h2 |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mask readback wrong");
  a_rdata_idle: assert property (
    !reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_rx_read: assert property (
    reg_re_i && reg_addr_i == 4'h3 |=> reg_rdata_o == $past(rx_byte_o))
    else $error("rx byte read wrong");
  a_mskld_silent: assert property (
    port_mode_o == 4'h9 |-> sda_oen_o)
    else $error("ack in mask load mode");
  a_ack_scl_low: assert property (
    $fell(sda_oen_o) |-> !scl_i)
    else $error("ack starts with clock high");
  a_ack_width: assert property (
    $fell(sda_oen_o) |=> !sda_oen_o [*8] ##[1:30] sda_oen_o)
    else $error("ack length wrong");
  a_match_acks: assert property (
    $rose(buf_full_o) |-> ##[1:20] $fell(sda_oen_o))
    else $error("accepted byte not acked");

  c_ack: cover property ($fell(sda_oen_o));
  c_irq: cover property ($rose(irq_o));
  c_mskld_rd: cover property (reg_re_i && reg_addr_i == 4'h2 && port_mode_o == 4'h9);
endmodule

bind i2cam_top i2cam_properties i2cam_properties_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oen_o(sda_oen_o), .slew_limit_o(slew_limit_o),
  .buf_full_o(buf_full_o), .rx_byte_o(rx_byte_o), .port_mode_o(port_mode_o), .irq_o(irq_o)
);

/* tb/test_i2c_slave_address_match.sv */
// self-checking bench for the i2c slave address match block
module test_i2c_slave_address_match;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0;
  logic       rstn_i, reg_we_i, reg_re_i, scl, sda_m, ack;
  logic [3:0] reg_addr_i, port_mode_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, rx_byte_o, v;
  logic       sda_o, sda_oen_o, slew_limit_o, buf_full_o, irq_o;
  wire  logic sda_bus;
  int         error_cnt = 0;
  int         n_checks = 0;
  // own, mask, byte, mode, expected ack
  logic [7:0] own_t[5] = '{8'hA4, 8'hA4, 8'hA4, 8'hA5, 8'h24};
  logic [7:0] msk_t[5] = '{8'hFF, 8'hFF, 8'hFD, 8'hFF, 8'hFF};
  logic [7:0] byt_t[5] = '{8'hA4, 8'hA6, 8'hA6, 8'hA4, 8'h24};
  logic [3:0] mod_t[5] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'hE};
  logic       exp_t[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  always #5 clk_i = ~clk_i;
  // sda link pin wired as an open-drain input, scl driven directly
  // open drain wire, pulled up unless someone pulls low
  assign sda_bus = sda_m & (sda_oen_o | sda_o);

  i2cam_top i2cam_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oen_o(sda_oen_o), .slew_limit_o(slew_limit_o),
    .buf_full_o(buf_full_o), .rx_byte_o(rx_byte_o), .port_mode_o(port_mode_o),
    .irq_o(irq_o)
  );
  i2cam_master i2cam_master_i (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_bus));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // limit on the whole run, a hang counts as a mismatch
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    rstn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h2, 8'h00);
    rchk(4'hA, 8'h00);
    chk({7'h0, slew_limit_o}, 8'h01);
    wr(4'h0, 8'h09);
    rchk(4'h2, 8'hFF);
    wr(4'h2, 8'h3C);
    rchk(4'h2, 8'h3C);
    wr(4'h0, 8'h06);
    rchk(4'h2, 8'h00);
    wr(4'h2, 8'h5A);
    rchk(4'h2, 8'h5A);
    wr(4'h0, 8'h09);
    rchk(4'h2, 8'h3C);
    // clock-edge bit kept clear, only the speed bit moves
    wr(4'h1, 8'h80);
    settle();
    chk({slew_limit_o, 7'h0}, 8'h00);
    rchk(4'h1, 8'h80);
    wr(4'h1, 8'h00);
    settle();
    chk({7'h0, slew_limit_o}, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(4'h0, 8'h29);
      wr(4'h2, msk_t[k]);
      wr(4'h0, {4'h2, mod_t[k]});
      wr(4'h2, own_t[k]);
      settle();
      chk({4'h0, port_mode_o}, {4'h0, mod_t[k]});
      i2cam_master_i.start();
      rd(4'h1, v);
      chk(v & 8'h18, 8'h08);
      i2cam_master_i.send(byt_t[k], ack);
      chk({7'h0, ack}, {7'h0, exp_t[k]});
      if (exp_t[k]) begin
        rchk(4'h3, byt_t[k]);
        // data byte acked once the buffer is read, refused while full
        i2cam_master_i.send(8'h5A, ack);
        chk({7'h0, ack}, 8'h01);
        chk(rx_byte_o, 8'h5A);
        rd(4'h1, v);
        chk(v & 8'h21, 8'h21);
        chk({7'h0, buf_full_o}, 8'h01);
        i2cam_master_i.send(8'hC3, ack);
        chk({7'h0, ack}, 8'h00);
        rchk(4'h3, 8'h5A);
      end
      i2cam_master_i.stop();
      rd(4'h1, v);
      chk(v & 8'h18, 8'h10);
    end
    // irq held off by the mask, then raised and cleared
    settle();
    chk({7'h0, irq_o}, 8'h00);
    wr(4'h5, 8'h01);
    settle();
    chk({7'h0, irq_o}, 8'h01);
    wr(4'h4, 8'h0F);
    settle();
    chk({7'h0, irq_o}, 8'h00);
    wr(4'h0, 8'h06);
    rd(4'h1, v);
    chk(v & 8'h18, 8'h00);
    // ten-bit: low byte bit 0 counts only with mask bit 0 set
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, 8'h29);
      wr(4'h2, k ? 8'hFF : 8'hFE);
      wr(4'h0, 8'h27);
      wr(4'h2, 8'hF0);
      i2cam_master_i.start();
      i2cam_master_i.send(8'hF0, ack);
      chk({7'h0, ack}, 8'h01);
      // high byte matched: software must reload the low address
      rd(4'h1, v);
      chk(v & 8'h02, 8'h02);
      wr(4'h2, 8'h35);
      i2cam_master_i.send(8'h34, ack);
      chk({7'h0, ack}, {7'h0, k == 0});
      i2cam_master_i.stop();
      if (k == 0)
        rchk(4'h3, 8'h34);
    end
    wrap_up();
  end
endmodule
